// File: verilog/smpk_packer.v
// sample interleave packer: high-rate samples onto single-speed link frames
`timescale 1ns/1ps
`include "smpk_consts.vh"
module smpk_packer #(
   parameter W = `SMPK_SAMPLE_W
) (
   // clock and reset
   input wire clk_sys_i,
   input wire arst_n_i,
   // rate selection
   input wire double_rate_mode_i,
   input wire quad_rate_mode_i,
   output wire sample_interleave_o,
   output wire sample_interleave_by_four_o,
   // link frame clock pin
   input wire link_frame_clk_i,
   // transmit sample stream, time-major, channel-minor
   input wire tx_smp_valid_i,
   input wire [W-1:0] tx_smp_data_i,
   output wire tx_smp_ready_o,
   output wire tx_underrun_o,
   // optical link transmit frame, slot 0 in the low bits
   output wire [`SMPK_SLOTS*W-1:0] link_tx_data_o,
   output wire link_tx_frame_o,
   // AES lines transmit words
   output wire [`SMPK_AES_LINES*W-1:0] aes_tx_left_o,
   output wire [`SMPK_AES_LINES*W-1:0] aes_tx_right_o,
   // optical link receive frame pins
   input wire [`SMPK_SLOTS*W-1:0] link_rx_data_i,
   // receive sample stream
   output wire rx_smp_valid_o,
   output wire [W-1:0] rx_smp_data_o,
   output wire [`SMPK_SLOT_W-1:0] rx_smp_chan_o,
   output wire [1:0] rx_smp_phase_o
);

   localparam SW = `SMPK_SLOT_W;
   localparam NS = `SMPK_SLOTS;
   localparam FW = `SMPK_SLOTS * W;

   // sample index within a frame to link slot
   function [SW-1:0] slot_of;
      input [`SMPK_MODE_W-1:0] mode;
      input [SW-1:0] k;
      begin
         if (mode == `SMPK_MODE_QUAD) begin
            slot_of = {k[0], k[2:1]};
         end else if (mode == `SMPK_MODE_DOUBLE) begin
            slot_of = {k[1:0], k[2]};
         end else begin
            slot_of = k;
         end
      end
   endfunction

   // audio channel of sample index k
   function [SW-1:0] chan_of;
      input [`SMPK_MODE_W-1:0] mode;
      input [SW-1:0] k;
      begin
         if (mode == `SMPK_MODE_QUAD) begin
            chan_of = {2'h0, k[0]};
         end else if (mode == `SMPK_MODE_DOUBLE) begin
            chan_of = {1'b0, k[1:0]};
         end else begin
            chan_of = k;
         end
      end
   endfunction

   // time phase of sample index k within a frame
   function [1:0] phase_of;
      input [`SMPK_MODE_W-1:0] mode;
      input [SW-1:0] k;
      begin
         if (mode == `SMPK_MODE_QUAD) begin
            phase_of = k[2:1];
         end else if (mode == `SMPK_MODE_DOUBLE) begin
            phase_of = {1'b0, k[2]};
         end else begin
            phase_of = 2'h0;
         end
      end
   endfunction

   wire frame_edge;
   reg [`SMPK_MODE_W-1:0] mode_d;
   reg [`SMPK_MODE_W-1:0] mode_q;
   reg [W-1:0] gather_q [0:NS-1];
   reg [SW:0] tx_cnt_q;
   reg [FW-1:0] tx_frame_q;
   reg frame_pulse_q;
   reg underrun_q;
   reg [FW-1:0] rx_s1_q;
   reg [FW-1:0] rx_s2_q;
   reg [FW-1:0] rx_s3_q;
   reg [FW-1:0] rx_frame_q;
   reg [`SMPK_MODE_W-1:0] rx_mode_q;
   reg [SW:0] rx_cnt_q;
   reg rx_valid_q;
   reg [W-1:0] rx_data_q;
   reg [SW-1:0] rx_chan_q;
   reg [1:0] rx_phase_q;
   reg [FW-1:0] frame_d;
   reg [SW-1:0] rx_slot;
   integer i;
   integer j;

   // link frame clock is sampled on the cleaned system clock
   smpk_sync_edge u_frame_sync (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .pin_i(link_frame_clk_i),
      .level_o(),
      .rise_o(frame_edge),
      .fall_o()
   );

   // quad wins if both modes are requested
   always @* begin
      if (quad_rate_mode_i) begin
         mode_d = `SMPK_MODE_QUAD;
      end else if (double_rate_mode_i) begin
         mode_d = `SMPK_MODE_DOUBLE;
      end else begin
         mode_d = `SMPK_MODE_SINGLE;
      end
   end

   // gathered samples flattened into slot order
   always @* begin
      frame_d = {FW{1'b0}};
      for (i = 0; i < NS; i = i + 1) begin
         frame_d[i*W +: W] = gather_q[i];
      end
   end

   assign tx_smp_ready_o = !tx_cnt_q[SW] && !frame_edge;

   // mode changes only at a frame boundary, never mid-frame
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_q <= `SMPK_MODE_SINGLE;
      end else if (frame_edge) begin
         mode_q <= mode_d;
      end
   end

   // transmit gather: one frame worth of samples between link edges
   // own loop index, so the flatten process stays the only writer of i
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_cnt_q <= {(SW+1){1'b0}};
         for (j = 0; j < NS; j = j + 1) begin
            gather_q[j] <= {W{1'b0}};
         end
      end else if (frame_edge) begin
         tx_cnt_q <= {(SW+1){1'b0}};
         for (j = 0; j < NS; j = j + 1) begin
            gather_q[j] <= {W{1'b0}};
         end
      end else if (tx_smp_valid_i && tx_smp_ready_o) begin
         gather_q[slot_of(mode_q, tx_cnt_q[SW-1:0])] <= tx_smp_data_i;
         tx_cnt_q <= tx_cnt_q + {{SW{1'b0}}, 1'b1};
      end
   end

   // one link frame per rising link frame clock edge, in every mode
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_frame_q <= {FW{1'b0}};
         frame_pulse_q <= 1'b0;
         underrun_q <= 1'b0;
      end else begin
         frame_pulse_q <= frame_edge;
         underrun_q <= frame_edge && !tx_cnt_q[SW];
         if (frame_edge) begin
            tx_frame_q <= frame_d;
         end
      end
   end

   assign link_tx_data_o = tx_frame_q;
   assign link_tx_frame_o = frame_pulse_q;
   assign tx_underrun_o = underrun_q;
   assign sample_interleave_o = (mode_q != `SMPK_MODE_SINGLE);
   assign sample_interleave_by_four_o = (mode_q == `SMPK_MODE_QUAD);

   // AES line n carries slots 2n (left) and 2n+1 (right)
   genvar g;
   generate
      for (g = 0; g < `SMPK_AES_LINES; g = g + 1) begin : g_aes
         assign aes_tx_left_o[g*W +: W] = tx_frame_q[(2*g)*W +: W];
         assign aes_tx_right_o[g*W +: W] = tx_frame_q[(2*g+1)*W +: W];
      end
   endgenerate

   // receive pins pass three flops, aligned with the edge detector
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_s1_q <= {FW{1'b0}};
         rx_s2_q <= {FW{1'b0}};
         rx_s3_q <= {FW{1'b0}};
      end else begin
         rx_s1_q <= link_rx_data_i;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
      end
   end

   always @* begin
      rx_slot = slot_of(rx_mode_q, rx_cnt_q[SW-1:0]);
   end

   // receive unpack: emit eight samples in time order after each frame
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_frame_q <= {FW{1'b0}};
         rx_mode_q <= `SMPK_MODE_SINGLE;
         rx_cnt_q <= {1'b1, {SW{1'b0}}};
         rx_valid_q <= 1'b0;
         rx_data_q <= {W{1'b0}};
         rx_chan_q <= {SW{1'b0}};
         rx_phase_q <= 2'h0;
      end else begin
         rx_valid_q <= 1'b0;
         if (frame_edge) begin
            rx_frame_q <= rx_s3_q;
            rx_mode_q <= mode_d;
            rx_cnt_q <= {(SW+1){1'b0}};
         end else if (!rx_cnt_q[SW]) begin
            rx_valid_q <= 1'b1;
            rx_data_q <= rx_frame_q[rx_slot*W +: W];
            rx_chan_q <= chan_of(rx_mode_q, rx_cnt_q[SW-1:0]);
            rx_phase_q <= phase_of(rx_mode_q, rx_cnt_q[SW-1:0]);
            rx_cnt_q <= rx_cnt_q + {{SW{1'b0}}, 1'b1};
         end
      end
   end

   assign rx_smp_valid_o = rx_valid_q;
   assign rx_smp_data_o = rx_data_q;
   assign rx_smp_chan_o = rx_chan_q;
   assign rx_smp_phase_o = rx_phase_q;

endmodule // smpk_packer

// File: verilog/smpk_consts.vh
// constants for the sample interleave packer
`ifndef SMPK_CONSTS_VH
`define SMPK_CONSTS_VH

// link frame geometry
`define SMPK_SLOTS 8
`define SMPK_SLOT_W 3
`define SMPK_AES_LINES 4
`define SMPK_SAMPLE_W 24

// rate modes
`define SMPK_MODE_W 2
`define SMPK_MODE_SINGLE 2'h0
`define SMPK_MODE_DOUBLE 2'h1
`define SMPK_MODE_QUAD 2'h2

// single-speed link frame rates in Hz
`define SMPK_LINK_FS_LOW_HZ 44100
`define SMPK_LINK_FS_HIGH_HZ 48000

// synchroniser depth for pins from outside the clock domain
`define SMPK_SYNC_STAGES 3

`endif

// File: verilog/smpk_sync_edge.v
// three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module smpk_sync_edge (
   // clock and reset
   input wire clk_sys_i,
   input wire arst_n_i,
   // pin side
   input wire pin_i,
   // synchronised side
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);

   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg level_q;

   // a change counts once stages two and three agree
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign level_o = level_q;
   assign rise_o = (s2_q == s3_q) && s3_q && !level_q;
   assign fall_o = (s2_q == s3_q) && !s3_q && level_q;

endmodule // smpk_sync_edge

// File: verif/smpk_checker.sv
// port assertions for the packer
`timescale 1ns/1ps
module smpk_checker #(parameter W = 24) (
   input wire clk_sys_i,
   input wire arst_n_i,
   input wire sample_interleave_o,
   input wire sample_interleave_by_four_o,
   input wire [8*W-1:0] link_tx_data_o,
   input wire link_tx_frame_o,
   input wire [4*W-1:0] aes_tx_left_o,
   input wire [4*W-1:0] aes_tx_right_o,
   input wire rx_smp_valid_o,
   input wire [2:0] rx_smp_chan_o,
   input wire [1:0] rx_smp_phase_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   logic [4*W-1:0] lft, rgt;
   always_comb for (int n = 0; n < 4; n++) begin
      lft[n*W +: W] = link_tx_data_o[2*n*W +: W];
      rgt[n*W +: W] = link_tx_data_o[(2*n+1)*W +: W];
   end
   sequence s_burst;
      rx_smp_valid_o [*8] ##1 !rx_smp_valid_o;
   endsequence
   property p_il;
      sample_interleave_by_four_o |-> sample_interleave_o;
   endproperty
   a_il: assert property (p_il) else $error("by-four flag alone");
   property p_frm;
      link_tx_frame_o |=> !link_tx_frame_o;
   endproperty
   a_frm: assert property (p_frm) else $error("frame pulse long");
   property p_hold;
      $changed(link_tx_data_o) |-> link_tx_frame_o;
   endproperty
   a_hold: assert property (p_hold) else $error("frame moved");
   property p_aes;
      aes_tx_left_o == lft && aes_tx_right_o == rgt;
   endproperty
   a_aes: assert property (p_aes) else $error("line words off");
   property p_run;
      $rose(rx_smp_valid_o) |-> s_burst;
   endproperty
   a_run: assert property (p_run) else $error("rx burst length");
   property p_ord;
      rx_smp_valid_o && $past(rx_smp_valid_o) && !sample_interleave_o
         |-> rx_smp_chan_o == $past(rx_smp_chan_o) + 3'h1;
   endproperty
   a_ord: assert property (p_ord) else $error("rx order");
   property p_quad;
      sample_interleave_by_four_o && rx_smp_valid_o |-> rx_smp_chan_o < 3'h2;
   endproperty
   a_quad: assert property (p_quad) else $error("quad channel");
   property p_dbl;
      sample_interleave_o && !sample_interleave_by_four_o && rx_smp_valid_o
         |-> rx_smp_chan_o < 3'h4 && rx_smp_phase_o < 2'h2;
   endproperty
   a_dbl: assert property (p_dbl) else $error("double tags");
endmodule // smpk_checker
bind smpk_packer smpk_checker #(.W(W)) smpk_checker_inst (
   .clk_sys_i(clk_sys_i),
   .arst_n_i(arst_n_i),
   .sample_interleave_o(sample_interleave_o),
   .sample_interleave_by_four_o(sample_interleave_by_four_o),
   .link_tx_data_o(link_tx_data_o),
   .link_tx_frame_o(link_tx_frame_o),
   .aes_tx_left_o(aes_tx_left_o),
   .aes_tx_right_o(aes_tx_right_o),
   .rx_smp_valid_o(rx_smp_valid_o),
   .rx_smp_chan_o(rx_smp_chan_o),
   .rx_smp_phase_o(rx_smp_phase_o)
);

// File: verif/smpk_far_end.sv
// far-end link equipment: frame clock and receive frame
`timescale 1ns/1ps
module smpk_far_end (
   output logic link_frame_clk_o,
   output logic [191:0] link_rx_data_o
);
   initial begin
      link_frame_clk_o = 1'b0;
      link_rx_data_o = 192'h0;
   end
   // one single-speed frame; clock still between frames
   task emit(input [191:0] d);
      begin
         link_rx_data_o = d;
         #40 link_frame_clk_o = 1'b1;
         #160 link_frame_clk_o = 1'b0;
         #120 link_rx_data_o = ~d;
      end
   endtask
endmodule // smpk_far_end

// File: verif/tb.sv
// bench for the sample interleave packer
`timescale 1ns/1ps
module tb;
   logic clk_sys_i = 1'b0, arst_n_i = 1'b0, dbl = 1'b0, quad = 1'b0;
   logic v = 1'b0;
   logic [23:0] txd = 24'h0;
   logic [191:0] cap = 192'h0, rxd;
   logic [28:0] q[$];
   wire lclk, il, il4, rdy, und, frm, rv;
   wire [191:0] lrx, ltx;
   wire [95:0] al, ar;
   wire [23:0] rd;
   wire [2:0] rc;
   wire [1:0] rp;
   integer err_total = 0, checks = 0, ucnt = 0, cyc = 0, i;
   always #20 clk_sys_i = ~clk_sys_i;
   smpk_far_end smpk_far_end_inst (.link_frame_clk_o(lclk),
      .link_rx_data_o(lrx));
   smpk_packer smpk_packer_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .double_rate_mode_i(dbl), .quad_rate_mode_i(quad),
      .sample_interleave_o(il), .sample_interleave_by_four_o(il4),
      .link_frame_clk_i(lclk), .tx_smp_valid_i(v), .tx_smp_data_i(txd),
      .tx_smp_ready_o(rdy), .tx_underrun_o(und), .link_tx_data_o(ltx),
      .link_tx_frame_o(frm), .aes_tx_left_o(al), .aes_tx_right_o(ar),
      .link_rx_data_i(lrx), .rx_smp_valid_o(rv), .rx_smp_data_o(rd),
      .rx_smp_chan_o(rc), .rx_smp_phase_o(rp));
   task end_sim;
      begin
         if (err_total == 0 && checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (frm === 1'b1) cap <= ltx;
      if (und === 1'b1) ucnt <= ucnt + 1;
      if (rv === 1'b1) q.push_back({rc, rp, rd});
      if (cyc == 3000) begin
         err_total = err_total + 1;
         end_sim;
      end
   end
   task chk(input string n, input [191:0] e, input [191:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("mismatch %s exp %h got %h", n, e, g);
         end
      end
   endtask
   // {chan, phase} of time-major sample k
   function [4:0] cp(input [2:0] k, input [1:0] m);
      cp = m == 2'h0 ? {k, 2'h0} : m == 2'h1 ?
         {1'b0, k[1:0], 1'b0, k[2]} : {2'h0, k[0], k[2:1]};
   endfunction
   function [2:0] sl(input [4:0] c, input [1:0] m);
      sl = m == 2'h0 ? c[4:2] : m == 2'h1 ? {c[3:2], c[0]} : c[2:0];
   endfunction
   task frame;
      begin
         q.delete();
         smpk_far_end_inst.emit(rxd);
         repeat (8) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task t_latch(input [1:0] m);
      integer j;
      begin
         dbl = m != 2'h0;
         quad = m == 2'h2;
         j = ucnt;
         frame;
         chk("underrun", j + 1, ucnt);
         chk("zero fill", 192'h0, cap);
         chk("interleave", m != 2'h0, il);
         chk("by four", m == 2'h2, il4);
         chk("rx count", 8, q.size());
         for (j = 0; j < 8 && j < q.size(); j++)
            chk("rx", {cp(j[2:0], m), 24'h000B00 + sl(cp(j[2:0], m), m)},
               q[j]);
      end
   endtask
   task t_pack(input [1:0] m);
      integer k;
      integer u;
      begin
         u = ucnt;
         for (k = 0; k < 8; k++) begin
            v = 1'b1;
            txd = 24'h0000A0 + k;
            // ready is settled here and holds until the taking edge
            while (rdy !== 1'b1) begin
               @(posedge clk_sys_i);
               #1;
            end
            @(posedge clk_sys_i);
            #1;
         end
         v = 1'b0;
         chk("refuse", 1'b0, rdy);
         frame;
         chk("no underrun", u, ucnt);
         for (k = 0; k < 8; k++)
            chk("slot", 24'h0000A0 + k, cap[sl(cp(k, m), m)*24 +: 24]);
         chk("line left", 24'h0000A0, al[23:0]);
         chk("line right", m == 2'h1 ? 24'h0000A4 : m == 2'h2 ?
            24'h0000A2 : 24'h0000A1, ar[23:0]);
         if (m == 2'h2)
            chk("quad line", 24'h0000A4, al[47:24]);
      end
   endtask
   initial begin
      for (i = 0; i < 8; i++)
         rxd[i*24 +: 24] = 24'h000B00 + i;
      repeat (5) @(posedge clk_sys_i);
      #1 arst_n_i = 1'b1;
      t_latch(2'h0);
      t_pack(2'h0);
      t_latch(2'h1);
      t_pack(2'h1);
      t_latch(2'h2);
      t_pack(2'h2);
      end_sim;
   end
endmodule // tb
